/* bench/uism_top_tb.sv */
// Self-checking bench for the serial-port interrupt status and mask block.
// Assumes the AXI4-Lite slave timing of uism_top: one write and one read at a time.
`timescale 1ns/1ps
`include "uism_params.svh"

module uism_top_tb;
  import uism_pkg::*;

  localparam int LIMIT = 20000;
  logic        clk;
  logic        rst_b;
  uism_src_t   src;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  uism_src_t   masked;
  int          error_cnt, check_count, cyc;

  ////////////////////////////////////////////////////////////////////////
  // Sources wired by the documented bit positions, not the design macros
  uism_top uism_top_i (
    .i_clk(clk), .i_rst_b(rst_b),
    .i_overrun_error_irq(src[10]), .i_break_error_irq(src[9]), .i_parity_error_irq(src[8]),
    .i_framing_error_irq(src[7]), .i_rx_timeout_irq(src[6]), .i_tx_level_irq(src[5]),
    .i_rx_level_irq(src[4]), .i_dataset_ready_change_irq(src[3]),
    .i_carrier_detect_change_irq(src[2]), .i_clear_to_send_change_irq(src[1]),
    .i_ring_indicator_change_irq(src[0]),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .o_masked_state(masked), .o_irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask

  // Handshakes and answers are taken at the rising edge; NBAs release only after it
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        input uism_src_t ev, input logic [1:0] exp_resp);
    logic aw_hs, w_hs, got;
    logic [1:0] resp;
    int n;
    n = 0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    src <= ev;
    do begin
      @(posedge clk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      got = (bvalid === 1'b1);
      resp = bresp;
      src <= '0;
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      n++;
    end while (!got && n < 100);
    bready <= 1'b0;
    chk("bresp", {30'h0, exp_resp}, got ? {30'h0, resp} : 32'hFFFF_FFFF);
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] exp_d, input logic [1:0] exp_resp);
    logic ar_hs, got;
    logic [31:0] d;
    logic [1:0] resp;
    int n;
    n = 0;
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      ar_hs = arvalid && arready;
      got = (rvalid === 1'b1);
      d = rdata;
      resp = rresp;
      if (ar_hs) arvalid <= 1'b0;
      n++;
    end while (!got && n < 100);
    rready <= 1'b0;
    chk("rresp", {30'h0, exp_resp}, got ? {30'h0, resp} : 32'hFFFF_FFFF);
    chk("rdata", exp_d, d);
  endtask

  task automatic pulse(input uism_src_t ev);
    src <= ev;
    @(posedge clk);
    src <= '0;
    @(posedge clk);
  endtask

  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    axi_rd(`UISM_OFS_MASK, 32'h0, `UISM_RESP_OKAY);
    axi_rd(`UISM_OFS_RAW, 32'h0, `UISM_RESP_OKAY);
    chk("irq", 32'h0, {31'h0, irq});
  endtask

  task automatic t_bitmap;
    axi_wr(`UISM_OFS_MASK, 32'h0000_07FF, 4'hF, '0, `UISM_RESP_OKAY);
    for (int i = 0; i < 11; i++) begin
      pulse(uism_src_t'(1 << i));
      axi_rd(`UISM_OFS_RAW, 32'h1 << i, `UISM_RESP_OKAY);
      chk("masked_state", 32'h1 << i, {21'h0, masked});
      chk("irq", 32'h1, {31'h0, irq});
      axi_wr(`UISM_OFS_CLR, 32'h1 << i, 4'hF, '0, `UISM_RESP_OKAY);
      axi_rd(`UISM_OFS_RAW, 32'h0, `UISM_RESP_OKAY);
      chk("irq", 32'h0, {31'h0, irq});
    end
  endtask

  task automatic t_mask;
    axi_wr(`UISM_OFS_MASK, 32'hFFFF_FFFF, 4'hF, '0, `UISM_RESP_OKAY);
    axi_rd(`UISM_OFS_MASK, 32'h0000_07FF, `UISM_RESP_OKAY);
    // Lane 0 only reaches bits 7:0, so bits 10:8 must survive
    axi_wr(`UISM_OFS_MASK, 32'h0, 4'h1, '0, `UISM_RESP_OKAY);
    axi_rd(`UISM_OFS_MASK, 32'h0000_0700, `UISM_RESP_OKAY);
    axi_wr(`UISM_OFS_MASK, 32'h0, 4'hF, '0, `UISM_RESP_OKAY);
    axi_rd(`UISM_OFS_MASK, 32'h0, `UISM_RESP_OKAY);
    axi_wr(`UISM_OFS_MASK, 32'h0000_0155, 4'hF, '0, `UISM_RESP_OKAY);
    do_reset();
    axi_rd(`UISM_OFS_MASK, 32'h0, `UISM_RESP_OKAY);
  endtask

  task automatic t_masked;
    axi_wr(`UISM_OFS_MASK, 32'h0000_0400, 4'hF, '0, `UISM_RESP_OKAY);
    pulse(11'h408);
    axi_rd(`UISM_OFS_RAW, 32'h0000_0408, `UISM_RESP_OKAY);
    axi_rd(`UISM_OFS_MSKD, 32'h0000_0400, `UISM_RESP_OKAY);
    chk("masked_state", 32'h0000_0400, {21'h0, masked});
    chk("irq", 32'h1, {31'h0, irq});
    axi_wr(`UISM_OFS_CLR, 32'h0, 4'hF, '0, `UISM_RESP_OKAY);
    axi_wr(`UISM_OFS_RAW, 32'h0, 4'hF, '0, `UISM_RESP_SLVERR);
    axi_wr(`UISM_OFS_MSKD, 32'h0, 4'hF, '0, `UISM_RESP_SLVERR);
    axi_rd(`UISM_OFS_RAW, 32'h0000_0408, `UISM_RESP_OKAY);
    axi_rd(`UISM_OFS_CLR, 32'h0, `UISM_RESP_SLVERR);
    axi_rd(12'h048, 32'h0, `UISM_RESP_SLVERR);
    axi_wr(12'h048, 32'hFFFF_FFFF, 4'hF, '0, `UISM_RESP_SLVERR);
    axi_wr(`UISM_OFS_MASK, 32'h0, 4'hF, '0, `UISM_RESP_OKAY);
    chk("irq", 32'h0, {31'h0, irq});
    axi_rd(`UISM_OFS_MSKD, 32'h0, `UISM_RESP_OKAY);
    axi_wr(`UISM_OFS_CLR, 32'h0000_07FF, 4'hF, '0, `UISM_RESP_OKAY);
    axi_rd(`UISM_OFS_RAW, 32'h0, `UISM_RESP_OKAY);
  endtask

  task automatic t_race;
    // Set pulse lands on the very edge that completes the clear
    axi_wr(`UISM_OFS_CLR, 32'h0000_0020, 4'hF, 11'h020, `UISM_RESP_OKAY);
    axi_rd(`UISM_OFS_RAW, 32'h0000_0020, `UISM_RESP_OKAY);
    axi_wr(`UISM_OFS_CLR, 32'h0000_0021, 4'hF, 11'h001, `UISM_RESP_OKAY);
    axi_rd(`UISM_OFS_RAW, 32'h0000_0001, `UISM_RESP_OKAY);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard, far above the roughly two hundred cycles the scenarios need
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial begin
    error_cnt = 0;
    check_count = 0;
    cyc = 0;
    rst_b = 1'b0;
    src = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    @(posedge clk);
    do_reset();
    t_reset();
    t_bitmap();
    t_mask();
    t_masked();
    t_race();
    tally_and_finish();
  end
endmodule // uism_top_tb

/* src/uism_params.svh */
// Constants for the serial-port interrupt status and mask block.
// Assumes inclusion by the package and the bench only.
`ifndef UISM_PARAMS_SVH
`define UISM_PARAMS_SVH

`define UISM_NUM_SRC        11
`define UISM_ADDR_W         12
`define UISM_DATA_W         32
`define UISM_OFS_MASK       12'h038
`define UISM_OFS_RAW        12'h03C
`define UISM_OFS_MSKD       12'h040
`define UISM_OFS_CLR        12'h044
`define UISM_MASK_RST       11'h000
`define UISM_RAW_RST        11'h000
`define UISM_BIT_OVERRUN    10
`define UISM_BIT_BREAK      9
`define UISM_BIT_PARITY     8
`define UISM_BIT_FRAMING    7
`define UISM_BIT_TIMEOUT    6
`define UISM_BIT_TX         5
`define UISM_BIT_RX         4
`define UISM_BIT_DSR        3
`define UISM_BIT_DCD        2
`define UISM_BIT_CTS        1
`define UISM_BIT_RI         0
`define UISM_RESP_OKAY      2'h0
`define UISM_RESP_SLVERR    2'h2

`endif

/* src/uism_pkg.sv */
// Types for the serial-port interrupt status and mask block.
// Assumes uism_params.svh is on the include path.
`include "uism_params.svh"

package uism_pkg;

  typedef logic [`UISM_NUM_SRC-1:0] uism_src_t;

  typedef enum logic [1:0] {
    UISM_WR_IDLE = 2'b00,
    UISM_WR_RESP = 2'b01
  } uism_wr_st_t;

  typedef enum logic [1:0] {
    UISM_RD_IDLE = 2'b00,
    UISM_RD_DATA = 2'b01
  } uism_rd_st_t;

  // Register-side state of the block
  typedef struct packed {
    uism_src_t              mask;
    uism_src_t              raw;
    uism_wr_st_t            wr_st;
    logic                   aw_got;
    logic                   w_got;
    logic [`UISM_ADDR_W-1:0] awaddr;
    logic [`UISM_DATA_W-1:0] wdata;
    logic [3:0]             wstrb;
    logic [1:0]             bresp;
    uism_rd_st_t            rd_st;
    logic [`UISM_DATA_W-1:0] rdata;
    logic [1:0]             rresp;
  } uism_state_t;

endpackage

/* src/uism_top.sv */
// Interrupt status and mask registers of a serial port, AXI4-Lite slave.
// Assumes single-cycle set pulses from the port's event logic, one clock.
`timescale 1ns/1ps

module uism_top
  import uism_pkg::*;
(
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_b,
  // Interrupt sources, one-cycle set pulses
  input  wire logic                    i_overrun_error_irq,
  input  wire logic                    i_break_error_irq,
  input  wire logic                    i_parity_error_irq,
  input  wire logic                    i_framing_error_irq,
  input  wire logic                    i_rx_timeout_irq,
  input  wire logic                    i_tx_level_irq,
  input  wire logic                    i_rx_level_irq,
  input  wire logic                    i_dataset_ready_change_irq,
  input  wire logic                    i_carrier_detect_change_irq,
  input  wire logic                    i_clear_to_send_change_irq,
  input  wire logic                    i_ring_indicator_change_irq,
  // AXI4-Lite write channels
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [`UISM_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  input  wire logic [`UISM_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  output logic [1:0]                   s_axi_bresp,
  // AXI4-Lite read channels
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  input  wire logic [`UISM_ADDR_W-1:0] s_axi_araddr,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic [`UISM_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  // Interrupt outputs
  output logic [`UISM_NUM_SRC-1:0]     o_masked_state,
  output logic                         o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Source vector in register bit order

  uism_src_t   src_set;
  uism_state_t st_ff;
  uism_state_t nxt_st;
  uism_src_t   masked;
  uism_src_t   clr_vec;
  logic        clr_hit;

  // placement of error, timeout, level and modem-change sources
  always_comb begin
    src_set                     = '0;
    src_set[`UISM_BIT_OVERRUN]  = i_overrun_error_irq;
    src_set[`UISM_BIT_BREAK]    = i_break_error_irq;
    src_set[`UISM_BIT_PARITY]   = i_parity_error_irq;
    src_set[`UISM_BIT_FRAMING]  = i_framing_error_irq;
    src_set[`UISM_BIT_TIMEOUT]  = i_rx_timeout_irq;
    src_set[`UISM_BIT_TX]       = i_tx_level_irq;
    src_set[`UISM_BIT_RX]       = i_rx_level_irq;
    src_set[`UISM_BIT_DSR]      = i_dataset_ready_change_irq;
    src_set[`UISM_BIT_DCD]      = i_carrier_detect_change_irq;
    src_set[`UISM_BIT_CTS]      = i_clear_to_send_change_irq;
    src_set[`UISM_BIT_RI]       = i_ring_indicator_change_irq;
  end

  // Byte lanes 0 and 1 carry all eleven bits; upper lanes hold nothing
  function automatic uism_src_t lane_merge(uism_src_t old_v, logic [`UISM_DATA_W-1:0] d,
                                           logic [3:0] be);
    uism_src_t r;
    r = old_v;
    if (be[0]) begin
      r[7:0] = d[7:0];
    end
    if (be[1]) begin
      r[`UISM_NUM_SRC-1:8] = d[`UISM_NUM_SRC-1:8];
    end
    return r;
  endfunction

  function automatic logic is_mapped(logic [`UISM_ADDR_W-1:0] a, logic is_wr);
    logic r;
    r = 1'b0;
    if (a == `UISM_OFS_MASK) begin
      r = 1'b1;
    end else if (a == `UISM_OFS_RAW) begin
      r = !is_wr;
    end else if (a == `UISM_OFS_MSKD) begin
      r = !is_wr;
    end else if (a == `UISM_OFS_CLR) begin
      r = is_wr;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // masked view is raw AND mask
  assign masked = st_ff.raw & st_ff.mask;

  always_comb begin
    logic do_wr;
    logic [`UISM_ADDR_W-1:0] wa;
    logic [`UISM_DATA_W-1:0] wd;
    logic [3:0] ws;
    do_wr   = 1'b0;
    wa      = st_ff.awaddr;
    wd      = st_ff.wdata;
    ws      = st_ff.wstrb;
    nxt_st  = st_ff;
    clr_vec = '0;
    clr_hit = 1'b0;

    // Write path: capture address and data in either order
    case (st_ff.wr_st)
      UISM_WR_IDLE: begin
        if (s_axi_awvalid && !st_ff.aw_got) begin
          nxt_st.aw_got = 1'b1;
          nxt_st.awaddr = s_axi_awaddr;
          wa            = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_ff.w_got) begin
          nxt_st.w_got = 1'b1;
          nxt_st.wdata = s_axi_wdata;
          nxt_st.wstrb = s_axi_wstrb;
          wd           = s_axi_wdata;
          ws           = s_axi_wstrb;
        end
        do_wr = nxt_st.aw_got && nxt_st.w_got;
        if (do_wr) begin
          nxt_st.aw_got = 1'b0;
          nxt_st.w_got  = 1'b0;
          nxt_st.wr_st  = UISM_WR_RESP;
          nxt_st.bresp  = is_mapped(wa, 1'b1) ? `UISM_RESP_OKAY : `UISM_RESP_SLVERR;
        end
      end
      UISM_WR_RESP: begin
        if (s_axi_bready) begin
          nxt_st.wr_st = UISM_WR_IDLE;
        end
      end
      default: begin
        nxt_st.wr_st = UISM_WR_IDLE;
      end
    endcase

    // Address decode for the committed write
    if (do_wr) begin
      if (wa == `UISM_OFS_MASK) begin
        // mask bits follow written ones and zeros
        nxt_st.mask = lane_merge(st_ff.mask, wd, ws);
      end else if (wa == `UISM_OFS_CLR) begin
        // only ones clear; zeros leave state
        clr_vec = lane_merge('0, wd, ws);
        clr_hit = 1'b1;
      end
    end

    // set applied after clear so set wins
    nxt_st.raw = (st_ff.raw & ~clr_vec) | src_set;

    // Read path; data registered on acceptance
    case (st_ff.rd_st)
      UISM_RD_IDLE: begin
        if (s_axi_arvalid) begin
          nxt_st.rd_st = UISM_RD_DATA;
          nxt_st.rresp = `UISM_RESP_OKAY;
          nxt_st.rdata = '0;
          if (s_axi_araddr == `UISM_OFS_MASK) begin
            nxt_st.rdata[`UISM_NUM_SRC-1:0] = st_ff.mask;
          end else if (s_axi_araddr == `UISM_OFS_RAW) begin
            nxt_st.rdata[`UISM_NUM_SRC-1:0] = st_ff.raw;
          end else if (s_axi_araddr == `UISM_OFS_MSKD) begin
            nxt_st.rdata[`UISM_NUM_SRC-1:0] = masked;
          end else begin
            // Clear register is write-only, so a read is refused like a hole
            nxt_st.rresp = `UISM_RESP_SLVERR;
          end
        end
      end
      UISM_RD_DATA: begin
        if (s_axi_rready) begin
          nxt_st.rd_st = UISM_RD_IDLE;
        end
      end
      default: begin
        nxt_st.rd_st = UISM_RD_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // modem raw bits cleared at reset anyway, a safe defined value
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_ff       <= '0;
      st_ff.mask  <= `UISM_MASK_RST;
      st_ff.raw   <= `UISM_RAW_RST;
      st_ff.wr_st <= UISM_WR_IDLE;
      st_ff.rd_st <= UISM_RD_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign s_axi_awready  = (st_ff.wr_st == UISM_WR_IDLE) && !st_ff.aw_got;
  assign s_axi_wready   = (st_ff.wr_st == UISM_WR_IDLE) && !st_ff.w_got;
  assign s_axi_bvalid   = (st_ff.wr_st == UISM_WR_RESP);
  assign s_axi_bresp    = st_ff.bresp;
  assign s_axi_arready  = (st_ff.rd_st == UISM_RD_IDLE);
  assign s_axi_rvalid   = (st_ff.rd_st == UISM_RD_DATA);
  assign s_axi_rdata    = st_ff.rdata;
  assign s_axi_rresp    = st_ff.rresp;
  assign o_masked_state = masked;
  // single line ORs all masked bits
  assign o_irq          = |masked;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  AST_OVERRUN_SET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_overrun_error_irq |=> st_ff.raw[10])
    else $error("overrun event not at raw bit 10");

  AST_BREAK_SET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_break_error_irq |=> st_ff.raw[9])
    else $error("break event not at raw bit 9");

  AST_PARITY_SET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_parity_error_irq |=> st_ff.raw[8])
    else $error("parity event not at raw bit 8");

  AST_FRAMING_SET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_framing_error_irq |=> st_ff.raw[7])
    else $error("framing event not at raw bit 7");

  AST_TIMEOUT_SET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_rx_timeout_irq |=> st_ff.raw[6])
    else $error("timeout event not at raw bit 6");

  AST_TX_SET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_tx_level_irq |=> st_ff.raw[5])
    else $error("transmit event not at raw bit 5");

  AST_RX_SET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_rx_level_irq |=> st_ff.raw[4])
    else $error("receive event not at raw bit 4");

  AST_DSR_DCD_SET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_dataset_ready_change_irq |=> st_ff.raw[`UISM_BIT_DSR])
      and (i_carrier_detect_change_irq |=> st_ff.raw[`UISM_BIT_DCD]))
    else $error("modem dsr or dcd event misplaced");

  AST_CTS_RI_SET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_clear_to_send_change_irq |=> st_ff.raw[`UISM_BIT_CTS])
      and (i_ring_indicator_change_irq |=> st_ff.raw[`UISM_BIT_RI]))
    else $error("modem cts or ri event misplaced");

  AST_MASK_READ: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == `UISM_OFS_MASK)
      |=> (s_axi_rvalid && s_axi_rdata == {21'h000000, $past(st_ff.mask)}))
    else $error("mask read value wrong");

  AST_MASK_WRITE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (s_axi_awvalid && s_axi_awready && s_axi_awaddr == `UISM_OFS_MASK
      && s_axi_wvalid && s_axi_wready && s_axi_wstrb == 4'hF)
      |=> (st_ff.mask == $past(s_axi_wdata[`UISM_NUM_SRC-1:0])))
    else $error("mask write not stored");

  AST_RAW_READ: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == `UISM_OFS_RAW)
      |=> (s_axi_rdata == {21'h000000, $past(st_ff.raw)}))
    else $error("raw status read wrong");

  AST_MSKD_READ: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == `UISM_OFS_MSKD)
      |=> (s_axi_rdata == {21'h000000, $past(st_ff.raw & st_ff.mask)}))
    else $error("masked status read wrong");

  AST_CLEAR: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (clr_hit && clr_vec[10] && !i_overrun_error_irq) |=> !st_ff.raw[10])
    else $error("clear write did not clear overrun");

  AST_IRQ_OR: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_irq == |(st_ff.raw & st_ff.mask))
    else $error("interrupt line not OR of masked bits");

  AST_CLEAR_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    clr_hit |=> (($past(st_ff.raw) & ~$past(clr_vec) & ~st_ff.raw) == '0))
    else $error("zero clear bit dropped pending state");

  AST_SET_WINS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    clr_hit |=> (($past(src_set) & ~st_ff.raw) == '0))
    else $error("clear beat simultaneous set");

endmodule // uism_top
